// ---- rtl/cmd_gen.sv ----
// Bus command and control generator driven by processor status lines.
//
// How it works
// (RQ1) Decode status code into bus command
// (RQ2) Peripheral mode: I/O commands ignore grant
// (RQ3) Peripheral mode: I/O commands issue without arbitration
// (RQ4) Peripheral mode: memory commands wait grant low
// (RQ5) System mode: all commands wait grant delay
// (RQ6) Early writes assert one phase before writes
// (RQ7) Acknowledge strobe behaves like I/O read
// (RQ8) Transceiver enable gates bus, direction selects
// (RQ9) Peripheral mode: dual output is data enable
// (RQ10) System mode: dual output is cascade enable
// (RQ11) Interrupt sequence is two acknowledge cycles
// (RQ12) Outside logic masks first cascade enable; here second_ack masks it inside the generator
// (RQ13) Cascade enable precedes second acknowledge cycle
// (RQ14) Address strobe pulses every machine cycle
// (RQ15) Strobe starts at later of edge, status
// (RQ16) Qualifier low forces commands inactive, driven
// (RQ17) Outside logic drops qualifier before T2
// (RQ18) Acknowledge output is active low
// (RQ19) Cascade enable high, data enable low
// (RQ20) System mode: grant high floats commands
// (RQ21) Halt and passive issue no command
`timescale 1ns/100ps
`default_nettype none

module cmd_gen #(
    parameter int GRANT_DELAY = cmd_gen_pkg::GRANT_DELAY_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Processor clock and status pins
    input wire logic cpu_clk,
    input wire logic status_line_zero,
    input wire logic status_line_one,
    input wire logic status_line_two,
    // Arbitration and strap pins
    input wire logic arbiter_grant_n,
    input wire logic peripheral_bus_strap,
    input wire logic command_qualifier,
    // Command outputs, active low
    output cmd_gen_pkg::command_s command,
    output logic command_oe_n,
    // Control outputs
    output logic address_strobe,
    output logic transceiver_enable,
    output logic transfer_direction,
    output logic dual_function_output
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Every processor, arbitration and strap pin is asynchronous to sys_clk, so each one passes two flip-flops first.
    // Reset values match the idle pin levels, which keeps false edges away.
    logic [6:0] sync_a;
    logic [6:0] sync_b;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync_a <= 7'h7f;
            sync_b <= 7'h7f;
        end
        else
        begin
            sync_a <= {cpu_clk, status_line_two, status_line_one, status_line_zero,
                arbiter_grant_n, peripheral_bus_strap, command_qualifier};
            sync_b <= sync_a;
        end
    end

    logic pclk;
    logic [2:0] status;
    logic grant_n;
    logic strap;
    logic qualifier;

    assign pclk = sync_b[6];
    assign status = sync_b[5:3];
    assign grant_n = sync_b[2];
    assign strap = sync_b[1];
    assign qualifier = sync_b[0];

    // ------------------------------------------------------------
    // Processor clock edges and status activity
    // ------------------------------------------------------------
    // The processor clock is only seen as a level sampled on sys_clk, so it must be
    // several times slower than sys_clk for the phases below to be resolved.
    logic pclk_q;
    logic [2:0] status_q;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            pclk_q <= 1'b1;
            status_q <= cmd_gen_pkg::ST_PASSIVE;
        end
        else
        begin
            pclk_q <= pclk;
            status_q <= status;
        end
    end

    logic pclk_fall;
    logic pclk_rise;
    logic status_start;
    logic status_end;

    assign pclk_fall = pclk_q && !pclk;
    assign pclk_rise = !pclk_q && pclk;
    assign status_start = (status_q == cmd_gen_pkg::ST_PASSIVE)
        && (status != cmd_gen_pkg::ST_PASSIVE);
    assign status_end = (status_q != cmd_gen_pkg::ST_PASSIVE)
        && (status == cmd_gen_pkg::ST_PASSIVE);

    // ------------------------------------------------------------
    // Machine cycle sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {IDLE, WAIT_EDGE, T1, T2, T3} phase_e;

    phase_e phase;
    logic [2:0] cycle_code;
    logic second_ack;

    // T3 lasts until the status goes passive, so a cycle stretched by wait states
    // is still covered by one unbroken command.
    // Strobe waits for whichever comes later: status going active or a falling edge.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            phase <= IDLE;
        else
        begin
            case (phase)
                IDLE:
                    if (status_start)
                        phase <= pclk ? WAIT_EDGE : T1; // RQ15
                WAIT_EDGE:
                    if (status == cmd_gen_pkg::ST_PASSIVE)
                        phase <= IDLE;
                    else if (pclk_fall)
                        phase <= T1; // RQ15
                T1:
                    if (pclk_rise)
                        phase <= T2;
                T2:
                    if (pclk_fall)
                        phase <= T3;
                T3:
                    if (status_end)
                        phase <= IDLE; // RQ21
                default:
                    phase <= IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            cycle_code <= cmd_gen_pkg::ST_PASSIVE;
        else if (phase == IDLE && status_start)
            cycle_code <= status; // RQ14
    end

    // The second of two back-to-back acknowledge cycles is tracked here.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            second_ack <= 1'b0;
        else if (phase == T3 && status_end)
            second_ack <= (cycle_code == cmd_gen_pkg::ST_INT_ACK) && !second_ack; // RQ11
    end

    // ------------------------------------------------------------
    // Arbitration delay
    // ------------------------------------------------------------
    // The counter saturates, so a long grant never wraps back into the wait.
    // Any loss of the grant clears it, and the full delay is served again.
    logic [7:0] grant_count;
    logic grant_ready;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            grant_count <= 8'h0;
        else if (grant_n)
            grant_count <= 8'h0;
        else if (grant_count < 8'(GRANT_DELAY))
            grant_count <= grant_count + 8'h1;
    end

    assign grant_ready = !grant_n && (grant_count >= 8'(GRANT_DELAY)); // RQ5

    // ------------------------------------------------------------
    // Command decode and gating
    // ------------------------------------------------------------
    logic is_io;
    logic is_mem;
    logic allowed;
    logic in_cmd;
    logic in_early;
    cmd_gen_pkg::command_s next_command;

    // Acknowledge counts as I/O: it sits on the peripheral side.
    assign is_io = (cycle_code == cmd_gen_pkg::ST_INT_ACK)
        || (cycle_code == cmd_gen_pkg::ST_IO_READ)
        || (cycle_code == cmd_gen_pkg::ST_IO_WRITE);
    assign is_mem = cycle_code[2] && (cycle_code != cmd_gen_pkg::ST_PASSIVE);
    assign allowed = strap ? (is_io || (is_mem && !grant_n)) // RQ2 RQ3 RQ4
        : grant_ready; // RQ5
    assign in_early = (phase == T2) || (phase == T3);
    assign in_cmd = (phase == T3);

    // The decode is combinational and registered below, which keeps its glitches
    // off the command pins.
    always_comb
    begin
        next_command = cmd_gen_pkg::CMD_IDLE;
        if (allowed && qualifier) // RQ16
        begin
            case (cycle_code)
                cmd_gen_pkg::ST_INT_ACK:
                    next_command.interrupt_acknowledge_cmd = !in_early; // RQ7 RQ18
                cmd_gen_pkg::ST_IO_READ:
                    next_command.io_read_cmd = !in_early;
                cmd_gen_pkg::ST_IO_WRITE:
                begin
                    next_command.early_io_write_cmd = !in_early; // RQ6
                    next_command.io_write_cmd = !in_cmd;
                end
                cmd_gen_pkg::ST_CODE_READ, cmd_gen_pkg::ST_MEM_READ:
                    next_command.memory_read_cmd = !in_early;
                cmd_gen_pkg::ST_MEM_WRITE:
                begin
                    next_command.early_memory_write_cmd = !in_early; // RQ6
                    next_command.memory_write_cmd = !in_cmd;
                end
                default:
                    next_command = cmd_gen_pkg::CMD_IDLE; // RQ21
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            command <= cmd_gen_pkg::CMD_IDLE;
        else
            command <= next_command; // RQ1
    end

    // Floated only in system mode while the grant is away.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            command_oe_n <= 1'b0;
        else
            command_oe_n <= !strap && grant_n; // RQ20
    end

    // ------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------
    // In peripheral mode the I/O transfers use the dual output and not the
    // transceiver enable, so the two transceivers never drive together.
    logic active_cycle;
    logic is_read;

    assign active_cycle = (cycle_code != cmd_gen_pkg::ST_PASSIVE)
        && (cycle_code != cmd_gen_pkg::ST_HALT);
    // Acknowledge fetches a vector, so it counts as a read for the direction.
    assign is_read = (cycle_code != cmd_gen_pkg::ST_IO_WRITE)
        && (cycle_code != cmd_gen_pkg::ST_MEM_WRITE);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            {address_strobe, transceiver_enable, transfer_direction,
                dual_function_output} <= cmd_gen_pkg::CTL_IDLE;
        end
        else
        begin
            address_strobe <= (phase == T1); // RQ14 RQ15
            transfer_direction <= !(phase != IDLE && active_cycle && is_read); // RQ8
            transceiver_enable <= in_early && active_cycle && qualifier
                && !(strap && is_io) && allowed; // RQ8
            if (strap)
                dual_function_output <= !(in_early && is_io && active_cycle
                    && qualifier); // RQ9 RQ19
            else
                dual_function_output <= (phase == T1)
                    && (cycle_code == cmd_gen_pkg::ST_INT_ACK) && second_ack; // RQ10 RQ13
        end
    end

endmodule

`default_nettype wire

// ---- rtl/cmd_gen_pkg.sv ----
// Package: constants and carriers for the status-line bus command generator.
package cmd_gen_pkg;

    // ------------------------------------------------------------
    // Status codes (active-low lines, order two/one/zero)
    // ------------------------------------------------------------
    localparam logic [2:0] ST_INT_ACK = 3'h0;
    localparam logic [2:0] ST_IO_READ = 3'h1;
    localparam logic [2:0] ST_IO_WRITE = 3'h2;
    localparam logic [2:0] ST_HALT = 3'h3;
    localparam logic [2:0] ST_CODE_READ = 3'h4;
    localparam logic [2:0] ST_MEM_READ = 3'h5;
    localparam logic [2:0] ST_MEM_WRITE = 3'h6;
    localparam logic [2:0] ST_PASSIVE = 3'h7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    // Minimum delay from grant low to first command in system bus mode.
    localparam int GRANT_DELAY_NS = 110;
    localparam int GRANT_DELAY_CYCLES =
        (GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Output carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic memory_read_cmd;
        logic memory_write_cmd;
        logic early_memory_write_cmd;
        logic io_read_cmd;
        logic io_write_cmd;
        logic early_io_write_cmd;
        logic interrupt_acknowledge_cmd;
    } command_s;

    // All commands inactive (active-low outputs).
    localparam command_s CMD_IDLE = 7'h7f;

    typedef struct packed {
        logic address_strobe;
        logic transceiver_enable;
        logic transfer_direction;
        logic dual_function_output;
    } control_s;

    // Idle levels: strobe low, transceiver off, direction high, dual output high.
    localparam control_s CTL_IDLE = 4'h3;

endpackage

// ---- testbench/cmd_gen_properties.sv ----
// Checker with port-level properties of the bus command generator.
`timescale 1ns/100ps
`default_nettype none
module cmd_gen_checker #(
    parameter int GRANT_DELAY = 1
) (
    // Clock, reset and inputs
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic arbiter_grant_n,
    input wire logic peripheral_bus_strap,
    input wire logic command_qualifier,
    // Outputs
    input wire cmd_gen_pkg::command_s command,
    input wire logic command_oe_n,
    input wire logic address_strobe,
    input wire logic transfer_direction,
    input wire logic dual_function_output
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_legal_cmd_set: assert property (command inside {7'h7f, 7'h3f, 7'h6f, 7'h4f, 7'h5f,
        7'h77, 7'h7d, 7'h79, 7'h7b, 7'h7e}) else $error("illegal command pattern");
    a_qual_holds_idle: assert property (!command_qualifier [*5] |->
        command == cmd_gen_pkg::CMD_IDLE) else $error("command while qualifier low");
    a_grant_floats: assert property ((!peripheral_bus_strap && arbiter_grant_n) [*5] |->
        command_oe_n) else $error("commands driven while grant high");
    a_grant_delay_wait: assert property (!peripheral_bus_strap && $fell(arbiter_grant_n) |->
        command == cmd_gen_pkg::CMD_IDLE [*4]) else $error("command too soon after grant");
    a_mem_needs_grant: assert property ((peripheral_bus_strap && arbiter_grant_n) [*5] |->
        command.memory_read_cmd && command.memory_write_cmd) else $error("memory without grant");
    a_early_write_first: assert property ($fell(command.memory_write_cmd) |->
        !$past(command.early_memory_write_cmd)) else $error("early write came late");
    a_read_direction: assert property (!(command.memory_read_cmd && command.io_read_cmd &&
        command.interrupt_acknowledge_cmd) |-> !transfer_direction) else $error("read direction");
    a_cascade_with_strobe: assert property (!peripheral_bus_strap [*8] ##0 dual_function_output
        |-> address_strobe) else $error("cascade enable outside strobe");
    a_strobe_pulse_ends: assert property ($rose(address_strobe) |-> ##[1:40] !address_strobe)
        else $error("strobe stuck high");
    c_ack_cascade: cover property (!command.interrupt_acknowledge_cmd && dual_function_output);
    c_mem_write: cover property (!command.memory_write_cmd);
    c_floated: cover property (command_oe_n);
endmodule
bind cmd_gen cmd_gen_checker #(.GRANT_DELAY(GRANT_DELAY)) checker_i (.sys_clk(sys_clk),
    .rst(rst), .arbiter_grant_n(arbiter_grant_n), .peripheral_bus_strap(peripheral_bus_strap),
    .command_qualifier(command_qualifier), .command(command), .command_oe_n(command_oe_n),
    .address_strobe(address_strobe), .transfer_direction(transfer_direction),
    .dual_function_output(dual_function_output));
`default_nettype wire

// ---- testbench/cpu_status_bus_command_generator_tb.sv ----
// Testbench with directed scenarios for the bus command generator.
`timescale 1ns/100ps
`default_nettype none
module cpu_status_bus_command_generator_tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req = 1'b0;
    logic [2:0] code = 3'h7;
    logic arbiter_grant_n = 1'b0;
    logic peripheral_bus_strap = 1'b1;
    logic command_qualifier = 1'b1;
    logic busy, cpu_clk, st0, st1, st2, oe_n, strobe, enable, dir, dual;
    cmd_gen_pkg::command_s command;
    logic [6:0] acc;
    logic [5:0] saw;
    int fail_count = 0;
    int checks = 0;
    int ticks = 0;
    always #20 sys_clk = ~sys_clk;
    cpu_status_model cpu (.sys_clk(sys_clk), .req(req), .code(code), .busy(busy),
        .cpu_clk(cpu_clk), .status_line_zero(st0), .status_line_one(st1), .status_line_two(st2));
    cmd_gen #(.GRANT_DELAY(1)) uut (.sys_clk(sys_clk), .rst(rst), .cpu_clk(cpu_clk),
        .status_line_zero(st0), .status_line_one(st1), .status_line_two(st2),
        .arbiter_grant_n(arbiter_grant_n), .peripheral_bus_strap(peripheral_bus_strap),
        .command_qualifier(command_qualifier), .command(command), .command_oe_n(oe_n),
        .address_strobe(strobe), .transceiver_enable(enable), .transfer_direction(dir),
        .dual_function_output(dual));
    // ------------------------------------------------------------
    // Sampling away from the driving edge keeps the record free of races.
    // ------------------------------------------------------------
    // The record is cleared while a request waits for the model to take it.
    always @(negedge sys_clk)
    begin
        if (req && !busy)
        begin
            acc <= 7'h7f;
            saw <= 6'h0;
        end
        else
        begin
            acc <= acc & command;
            saw <= saw | {strobe, ~dir, dual, ~dual, oe_n, enable};
        end
    end
    always @(posedge sys_clk)
    begin
        ticks <= ticks + 1;
        if (ticks == 20000)
        begin
            fail_count = fail_count + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check_cmd(input string what, input logic [6:0] exp, input logic [6:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic check_flag(input string what, input logic exp, input logic got);
        check_cmd(what, {6'h0, exp}, {6'h0, got});
    endtask
    task automatic run(input logic [2:0] c);
        @(posedge sys_clk);
        req <= 1'b1;
        code <= c;
        while (busy !== 1'b1) @(posedge sys_clk);
        req <= 1'b0;
        while (busy !== 1'b0) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
    endtask
    task automatic test_decode();
        logic [6:0] exp [8] = '{7'h7e, 7'h77, 7'h79, 7'h7f, 7'h3f, 7'h3f, 7'h4f, 7'h7f};
        for (int i = 0; i < 8; i++)
        begin
            run(i[2:0]);
            check_cmd("command", exp[i], acc);
            check_flag("strobe", i != 7, saw[5]);
            check_flag("read direction", i inside {0, 1, 4, 5}, saw[4]);
            check_flag("transceiver", i inside {4, 5, 6}, saw[0]);
        end
    endtask
    task automatic test_qualifier();
        command_qualifier <= 1'b0;
        run(3'h5);
        check_cmd("qualified read", 7'h7f, acc);
        check_flag("floated", 1'b0, saw[1]);
        run(3'h2);
        check_cmd("qualified write", 7'h7f, acc);
        command_qualifier <= 1'b1;
    endtask
    task automatic test_peripheral();
        arbiter_grant_n <= 1'b1;
        run(3'h1);
        check_cmd("io read", 7'h77, acc);
        check_flag("data enable", 1'b1, saw[2]);
        run(3'h5);
        check_cmd("memory read", 7'h7f, acc);
        arbiter_grant_n <= 1'b0;
    endtask
    task automatic test_system();
        @(posedge sys_clk);
        peripheral_bus_strap <= 1'b0;
        arbiter_grant_n <= 1'b1;
        run(3'h1);
        check_cmd("io read held", 7'h7f, acc);
        check_flag("floated", 1'b1, saw[1]);
        arbiter_grant_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        run(3'h1);
        check_cmd("io read", 7'h77, acc);
        check_flag("floated", 1'b0, saw[1]);
        run(3'h0);
        check_flag("first cascade", 1'b0, saw[3]);
        run(3'h0);
        check_cmd("acknowledge", 7'h7e, acc);
        check_flag("second cascade", 1'b1, saw[3]);
    endtask
    initial
    begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        test_decode();
        test_qualifier();
        test_peripheral();
        test_system();
        print_verdict();
    end
endmodule
`default_nettype wire

// ---- testbench/cpu_status_model.sv ----
// Processor model that makes the slow clock and runs one status cycle per request.
`timescale 1ns/100ps
`default_nettype none
module cpu_status_model (
    // Bench side
    input wire logic sys_clk,
    input wire logic req,
    input wire logic [2:0] code,
    output logic busy,
    // Processor pins
    output logic cpu_clk,
    output logic status_line_zero,
    output logic status_line_one,
    output logic status_line_two
);
    logic [2:0] div = 3'h0;
    logic [2:0] phase = 3'h0;
    initial
    begin
        busy = 1'b0;
        cpu_clk = 1'b1;
        {status_line_two, status_line_one, status_line_zero} = cmd_gen_pkg::ST_PASSIVE;
    end
    // ------------------------------------------------------------
    // Status moves mid-way through the high phase, clear of both clock edges.
    // ------------------------------------------------------------
    always @(posedge sys_clk)
    begin
        div <= div + 3'h1;
        if (div == 3'h7)
            cpu_clk <= ~cpu_clk;
        if (div == 3'h3 && cpu_clk && !busy && req)
        begin
            busy <= 1'b1;
            phase <= 3'h0;
            {status_line_two, status_line_one, status_line_zero} <= code;
        end
        else if (div == 3'h3 && cpu_clk && busy)
        begin
            phase <= phase + 3'h1;
            if (phase == 3'h2)
                {status_line_two, status_line_one, status_line_zero} <= cmd_gen_pkg::ST_PASSIVE;
            if (phase == 3'h3)
                busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire
